// ===== i2c_host_model.sv
// two-wire bus master model that clocks the register slave from the host side
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
    // clock
    input  wire logic i_clk,
    // bus lines; data is open drain, high means released
    input  wire logic i_sda_wire,
    output logic      o_scl,
    output logic      o_sda_rel
);
    // ************************************************************
    // bus phases, eight system clocks per bus clock
    // ************************************************************
    initial begin
        o_scl     = 1'b1;
        o_sda_rel = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask : tick
    // clock stands still between frames; start and repeated start share one path
    task automatic start;
        tick(2);
        o_sda_rel = 1'b1;
        tick(2);
        o_scl = 1'b1;
        tick(2);
        o_sda_rel = 1'b0;
        tick(2);
        o_scl = 1'b0;
    endtask : start
    task automatic stop;
        tick(2);
        o_sda_rel = 1'b0;
        tick(2);
        o_scl = 1'b1;
        tick(2);
        o_sda_rel = 1'b1;
        tick(4);
    endtask : stop
    // data moves only mid-low; sampled mid-high where the slave answer has settled
    task automatic slot(input logic b, output logic s);
        tick(2);
        o_sda_rel = b;
        tick(2);
        o_scl = 1'b1;
        tick(2);
        s = i_sda_wire;
        tick(2);
        o_scl = 1'b0;
    endtask : slot
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) slot(d[i], s);
        slot(1'b1, s);
        ack = ~s;
    endtask : send
    task automatic recv(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) slot(1'b1, d[i]);
        slot(~more, s);
    endtask : recv
endmodule : i2c_host_model
`default_nettype wire

// ===== pmic_i2c_slave_regs.sv
// two-wire slave with the power-management control and status registers
`timescale 1ns/1ps
`default_nettype none
module pmic_i2c_slave_regs (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    // serial bus pins
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    // address strap and supply status
    input  wire logic       i_addr_select_pin,
    input  wire logic       i_pin_bank_supply,
    // port pins and analogue status
    input  wire logic [7:0] i_port_pin_in,
    input  wire logic [7:0] i_fault_events,
    input  wire logic [7:0] i_overload_events,
    input  wire logic [7:0] i_power_good_flags,
    // register contents toward the analogue blocks
    output logic [7:0]      o_port_pins_0_1_setup,
    output logic [7:0]      o_port_pins_2_3_setup,
    output logic [7:0]      o_port_pins_4_5_setup,
    output logic [7:0]      o_port_pins_6_7_setup,
    output logic [7:0]      o_port_pin_levels,
    output logic [7:0]      o_duty_bank_zero,
    output logic [7:0]      o_duty_bank_one,
    output logic [7:0]      o_rail_switch_control,
    output logic [7:0]      o_power_fail_keep_mask,
    output logic [7:0]      o_operating_options,
    output logic [7:0]      o_trim_rail_setpoint,
    output logic [7:0]      o_step_up_current_setpoint,
    output logic [7:0]      o_step_up_voltage_setpoint,
    output logic [7:0]      o_fault_clear_cmd,
    output logic            o_fault_alert_out_b
);
    typedef struct packed {
        pmic_regs_pkg::link_state_t st;
        logic [3:0]      bitcnt;
        logic [7:0]      shreg;
        logic [7:0]      ptr;
        logic            rw;
        logic            sda_oe;
        logic            scl_s1, scl_s2, scl_s3;
        logic            sda_s1, sda_s2, sda_s3;
        logic            asel_s1, asel_s2;
        logic            sup_s1, sup_s2, sup_s3;
        logic            addr_sel;
        logic            addr_done;
        logic [7:0]      pin_s1, pin_s2;
        logic [3:0][7:0] cfg;
        logic [7:0]      levels, duty0, duty1, rail, keep, opts;
        logic [7:0]      trim, cur, volt, fault, over, pgood, clr;
        logic            alert_b;
    } state_t;

    state_t q, d;
    logic       scl_rise, scl_fall, start_c, stop_c, wr_en;
    logic [7:0] rd_byte;

    // ************************************************************
    // helpers
    // ************************************************************
    // a pin is an output whenever its two config bits are not 00
    function automatic logic [7:0] out_mask(input logic [3:0][7:0] cfg);
        logic [7:0] m;
        m = 8'h00;
        for (int k = 0; k < 4; k++) begin
            m[2*k]   = |cfg[k][1:0];
            m[2*k+1] = |cfg[k][5:4];
        end
        return m;
    endfunction : out_mask

    function automatic logic [7:0] reg_read(input state_t s, input logic [7:0] a);
        logic [7:0] om;
        om = out_mask(s.cfg);
        case (a)
            8'h00, 8'h01, 8'h02, 8'h03: reg_read = s.cfg[a[1:0]];
            pmic_regs_pkg::OFS_LEVELS:  reg_read = (s.levels & om) | (s.pin_s2 & ~om);
            pmic_regs_pkg::OFS_DUTY0:   reg_read = s.duty0;
            pmic_regs_pkg::OFS_DUTY1:   reg_read = s.duty1;
            pmic_regs_pkg::OFS_RAIL:    reg_read = s.rail;
            pmic_regs_pkg::OFS_KEEP:    reg_read = s.keep;
            pmic_regs_pkg::OFS_OPTS:    reg_read = s.opts;
            pmic_regs_pkg::OFS_TRIM:    reg_read = s.trim;
            pmic_regs_pkg::OFS_CUR:     reg_read = s.cur;
            pmic_regs_pkg::OFS_VOLT:    reg_read = s.volt;
            pmic_regs_pkg::OFS_FAULT:   reg_read = s.fault;
            pmic_regs_pkg::OFS_OVER:    reg_read = s.over;
            pmic_regs_pkg::OFS_PGOOD:   reg_read = s.pgood;
            pmic_regs_pkg::OFS_IDENT:   reg_read = pmic_regs_pkg::IDENT_VALUE;
            default:                    reg_read = 8'h00;
        endcase
    endfunction : reg_read

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        d = q;
        wr_en = 1'b0;
        rd_byte = reg_read(q, q.ptr);
        // the second stage of each synchroniser gives the level; scl, sda and supply edges compare it with the third
        d.scl_s1 = i_scl;
        d.scl_s2 = q.scl_s1;
        d.scl_s3 = q.scl_s2;
        d.sda_s1 = i_sda;
        d.sda_s2 = q.sda_s1;
        d.sda_s3 = q.sda_s2;
        d.asel_s1 = i_addr_select_pin;
        d.asel_s2 = q.asel_s1;
        d.sup_s1 = i_pin_bank_supply;
        d.sup_s2 = q.sup_s1;
        d.sup_s3 = q.sup_s2;
        d.pin_s1 = i_port_pin_in;
        d.pin_s2 = q.pin_s1;
        scl_rise = q.scl_s2 & ~q.scl_s3;
        scl_fall = ~q.scl_s2 & q.scl_s3;
        start_c  = q.scl_s2 & q.scl_s3 & ~q.sda_s2 & q.sda_s3;
        stop_c   = q.scl_s2 & q.scl_s3 & q.sda_s2 & ~q.sda_s3;

        // strap caught once, on the first supply rise after core reset
        if (q.sup_s2 && !q.sup_s3 && !q.addr_done) begin
            d.addr_sel  = q.asel_s2;
            d.addr_done = 1'b1;
        end

        // slave only: scl is never driven, sampled fast enough for 400 kHz
        if (start_c) begin
            d.st     = q.addr_done ? pmic_regs_pkg::LK_ADDR : pmic_regs_pkg::LK_IDLE;
            d.bitcnt = 4'h0;
            d.sda_oe = 1'b0;
        end else if (stop_c) begin
            d.st     = pmic_regs_pkg::LK_IDLE;
            d.sda_oe = 1'b0;
        end else begin
            case (q.st)
                pmic_regs_pkg::LK_IDLE: begin
                    d.sda_oe = 1'b0;
                end
                pmic_regs_pkg::LK_ADDR, pmic_regs_pkg::LK_PTR, pmic_regs_pkg::LK_WDATA: begin
                    if (scl_rise) begin
                        d.shreg  = {q.shreg[6:0], q.sda_s2};
                        d.bitcnt = q.bitcnt + 4'h1;
                    end else if (scl_fall && q.bitcnt == pmic_regs_pkg::BITS_PER_BYTE) begin
                        d.bitcnt = 4'h0;
                        d.sda_oe = 1'b1;
                        if (q.st == pmic_regs_pkg::LK_ADDR) begin
                            if (q.shreg[7:1] == (q.addr_sel ? pmic_regs_pkg::ADDR_WR_HIGH[7:1]
                                                            : pmic_regs_pkg::ADDR_WR_LOW[7:1])) begin
                                d.rw = q.shreg[0];
                                d.st = pmic_regs_pkg::LK_ADDR_ACK;
                            end else begin
                                d.sda_oe = 1'b0;
                                d.st     = pmic_regs_pkg::LK_IDLE;
                            end
                        end else if (q.st == pmic_regs_pkg::LK_PTR) begin
                            d.ptr = q.shreg;
                            d.st  = pmic_regs_pkg::LK_PTR_ACK;
                        end else begin
                            wr_en = 1'b1;
                            d.st  = pmic_regs_pkg::LK_WDATA_ACK;
                        end
                    end
                end
                pmic_regs_pkg::LK_ADDR_ACK, pmic_regs_pkg::LK_RNEXT: begin
                    if (scl_fall) begin
                        if (q.st == pmic_regs_pkg::LK_RNEXT || q.rw) begin
                            d.shreg  = rd_byte;
                            d.ptr    = q.ptr + 8'h01;
                            d.sda_oe = ~rd_byte[7];
                            d.bitcnt = 4'h1;
                            d.st     = pmic_regs_pkg::LK_RDATA;
                        end else begin
                            d.sda_oe = 1'b0;
                            d.st     = pmic_regs_pkg::LK_PTR;
                        end
                    end
                end
                pmic_regs_pkg::LK_PTR_ACK: begin
                    if (scl_fall) begin
                        d.sda_oe = 1'b0;
                        d.st     = pmic_regs_pkg::LK_WDATA;
                    end
                end
                pmic_regs_pkg::LK_WDATA_ACK: begin
                    if (scl_fall) begin
                        d.sda_oe = 1'b0;
                        d.st     = pmic_regs_pkg::LK_PTR;
                    end
                end
                pmic_regs_pkg::LK_RDATA: begin
                    if (scl_fall) begin
                        if (q.bitcnt == pmic_regs_pkg::BITS_PER_BYTE) begin
                            d.sda_oe = 1'b0;
                            d.st     = pmic_regs_pkg::LK_RACK;
                        end else begin
                            d.shreg  = {q.shreg[6:0], 1'b0};
                            d.sda_oe = ~q.shreg[6];
                            d.bitcnt = q.bitcnt + 4'h1;
                        end
                    end
                end
                pmic_regs_pkg::LK_RACK: begin
                    if (scl_rise) begin
                        d.st = q.sda_s2 ? pmic_regs_pkg::LK_IDLE : pmic_regs_pkg::LK_RNEXT;
                    end
                end
                default: begin
                    d.st     = pmic_regs_pkg::LK_IDLE;
                    d.sda_oe = 1'b0;
                end
            endcase
        end

        // ************************************************************
        // register writes
        // ************************************************************
        if (wr_en) begin
            case (q.ptr)
                8'h00, 8'h01, 8'h02, 8'h03: d.cfg[q.ptr[1:0]] = q.shreg;
                pmic_regs_pkg::OFS_LEVELS: d.levels = (q.levels & ~out_mask(q.cfg))
                                                    | (q.shreg & out_mask(q.cfg));
                pmic_regs_pkg::OFS_DUTY0: d.duty0 = q.shreg;
                pmic_regs_pkg::OFS_DUTY1: d.duty1 = q.shreg;
                pmic_regs_pkg::OFS_RAIL:  d.rail  = q.shreg & pmic_regs_pkg::MASK_RAIL;
                pmic_regs_pkg::OFS_KEEP:  d.keep  = q.shreg & pmic_regs_pkg::MASK_KEEP;
                pmic_regs_pkg::OFS_OPTS:  d.opts  = q.shreg & pmic_regs_pkg::MASK_OPTS;
                pmic_regs_pkg::OFS_TRIM:  d.trim  = q.shreg & pmic_regs_pkg::MASK_SETPT;
                pmic_regs_pkg::OFS_CUR:   d.cur   = q.shreg & pmic_regs_pkg::MASK_CUR;
                pmic_regs_pkg::OFS_VOLT:  d.volt  = q.shreg & pmic_regs_pkg::MASK_SETPT;
                pmic_regs_pkg::OFS_CLEAR: d.clr   = q.shreg;
                default: ;
            endcase
        end

        // ************************************************************
        // fault capture
        // ************************************************************
        // clear command holds fault and overload clear and power good at FFh; detection only while 00h
        if (q.clr == pmic_regs_pkg::CLEAR_CMD) begin
            d.fault = pmic_regs_pkg::RST_ZERO;
            d.over  = pmic_regs_pkg::RST_ZERO;
            d.pgood = pmic_regs_pkg::RST_PGOOD;
        end else if (q.clr == pmic_regs_pkg::REARM_CMD) begin
            d.fault = q.fault | (i_fault_events & pmic_regs_pkg::MASK_FAULT);
            d.over  = q.over | (i_overload_events & pmic_regs_pkg::MASK_RAILFLAG);
            d.pgood = i_power_good_flags & pmic_regs_pkg::MASK_RAILFLAG;
        end
        d.alert_b = ~(|d.fault | |d.over);
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            q         <= '0;
            q.st      <= pmic_regs_pkg::LK_IDLE;
            q.pgood   <= pmic_regs_pkg::RST_PGOOD;
            q.alert_b <= 1'b1;
            q.scl_s1  <= 1'b1;
            q.scl_s2  <= 1'b1;
            q.scl_s3  <= 1'b1;
            q.sda_s1  <= 1'b1;
            q.sda_s2  <= 1'b1;
            q.sda_s3  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign o_sda_out                  = 1'b0;
    assign o_sda_oe                   = q.sda_oe;
    assign o_port_pins_0_1_setup      = q.cfg[0];
    assign o_port_pins_2_3_setup      = q.cfg[1];
    assign o_port_pins_4_5_setup      = q.cfg[2];
    assign o_port_pins_6_7_setup      = q.cfg[3];
    assign o_port_pin_levels          = q.levels;
    assign o_duty_bank_zero           = q.duty0;
    assign o_duty_bank_one            = q.duty1;
    assign o_rail_switch_control      = q.rail;
    assign o_power_fail_keep_mask     = q.keep;
    assign o_operating_options        = q.opts;
    assign o_trim_rail_setpoint       = q.trim;
    assign o_step_up_current_setpoint = q.cur;
    assign o_step_up_voltage_setpoint = q.volt;
    assign o_fault_clear_cmd          = q.clr;
    assign o_fault_alert_out_b        = q.alert_b;

    // ************************************************************
    // checks
    // ************************************************************
    // each property reads registered state, so it trails the next-state logic by a clock
    a_addr_value: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $rose(q.addr_done) |-> q.addr_sel == $past(q.asel_s2))
        else $error("address strap not latched");
    a_addr_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $past(q.addr_done) |-> q.addr_done && $stable(q.addr_sel))
        else $error("latched address changed");
    a_start_addr: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (start_c && q.addr_done) |=> q.st == pmic_regs_pkg::LK_ADDR && q.bitcnt == 4'h0)
        else $error("start not taken");
    a_stop_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (stop_c && !start_c) |=> q.st == pmic_regs_pkg::LK_IDLE && !q.sda_oe)
        else $error("stop did not idle the link");
    a_nine_bits: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        q.bitcnt <= pmic_regs_pkg::BITS_PER_BYTE)
        else $error("bit count past eight");
    a_ack_drive: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (q.st == pmic_regs_pkg::LK_PTR_ACK || q.st == pmic_regs_pkg::LK_WDATA_ACK) |-> q.sda_oe)
        else $error("acknowledge not driven");
    a_port_inputs: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (wr_en && q.ptr == pmic_regs_pkg::OFS_LEVELS) |=>
        ((q.levels ^ $past(q.levels)) & ~out_mask(q.cfg)) == 8'h00)
        else $error("input pin level written");
    a_clear_faults: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        q.clr == pmic_regs_pkg::CLEAR_CMD |=> q.fault == 8'h00 && q.over == 8'h00 && q.alert_b)
        else $error("clear command did not clear");
    a_clear_pgood: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        q.clr == pmic_regs_pkg::CLEAR_CMD |=> q.pgood == pmic_regs_pkg::RST_PGOOD)
        else $error("power good not set by clear");
    a_sda_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        q.st == pmic_regs_pkg::LK_IDLE |-> !q.sda_oe)
        else $error("data line driven while idle");
    a_read_first: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (q.st == pmic_regs_pkg::LK_ADDR_ACK && q.rw && scl_fall && !start_c && !stop_c) |=>
        q.st == pmic_regs_pkg::LK_RDATA && q.shreg == $past(rd_byte) && q.sda_oe != q.shreg[7])
        else $error("first read byte not loaded");
    a_unused_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (q.rail & ~pmic_regs_pkg::MASK_RAIL) == 8'h00 && (q.keep & ~pmic_regs_pkg::MASK_KEEP) == 8'h00
        && (q.opts & ~pmic_regs_pkg::MASK_OPTS) == 8'h00 && (q.trim & ~pmic_regs_pkg::MASK_SETPT) == 8'h00
        && (q.cur & ~pmic_regs_pkg::MASK_CUR) == 8'h00 && (q.volt & ~pmic_regs_pkg::MASK_SETPT) == 8'h00)
        else $error("unused bit stored");
    a_pgood_reset: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $past(!i_rst_b) |-> q.pgood == pmic_regs_pkg::RST_PGOOD && q.rail == 8'h00)
        else $error("bad reset value");
    a_read_inc: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (q.st == pmic_regs_pkg::LK_RNEXT && scl_fall && !start_c && !stop_c) |=>
        q.ptr == $past(q.ptr) + 8'h01 && q.st == pmic_regs_pkg::LK_RDATA)
        else $error("read pointer not advanced");
endmodule : pmic_i2c_slave_regs
`default_nettype wire

// ===== pmic_i2c_slave_regs_test.sv
// self-checking bench for the two-wire register slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module pmic_i2c_slave_regs_test;
    typedef struct packed {logic [7:0] ofs; logic [7:0] val; logic [7:0] exp;} row_t;
    // ************************************************************
    // signals
    // ************************************************************
    logic       clk, rst_b, strap, supply, scl, sda_rel, sda_out, sda_oe, alert_b, k, ack_ok;
    logic [7:0] pins_in, faults, overloads, pgood, dev;
    logic [7:0] p0, p1, p2, p3, levels, duty0, duty1, rail, keep, opts, trim, cur, volt, clr;
    logic [7:0] rdq [4];
    int         n_fail, compares;
    wire logic  sda_wire = sda_rel & (sda_oe ? sda_out : 1'b1);
    wire logic [111:0] all_regs = {p0, p1, p2, p3, levels, duty0, duty1, rail, keep, opts, trim, cur, volt, clr};
    row_t rows [14] = '{
        '{8'h00, 8'hA5, 8'hA5}, '{8'h03, 8'h5A, 8'h5A},
        '{8'h05, 8'h80, 8'h80}, '{8'h06, 8'h01, 8'h01},
        '{8'h07, 8'hFF, 8'hBF}, '{8'h08, 8'hFF, 8'hBD},
        '{8'h09, 8'hFF, 8'hD9}, '{8'h0A, 8'hFF, 8'hBF},
        '{8'h0B, 8'hFF, 8'h3F}, '{8'h0C, 8'hC1, 8'h81},
        '{8'h0D, 8'hFF, 8'h00}, '{8'h0F, 8'hFF, 8'hFD},
        '{8'h10, 8'h00, pmic_regs_pkg::IDENT_VALUE}, '{8'h12, 8'hAA, 8'h00}
    };
    pmic_i2c_slave_regs DUT (
        .i_clk(clk), .i_rst_b(rst_b), .i_scl(scl), .i_sda(sda_wire), .o_sda_out(sda_out),
        .o_sda_oe(sda_oe), .i_addr_select_pin(strap), .i_pin_bank_supply(supply),
        .i_port_pin_in(pins_in), .i_fault_events(faults), .i_overload_events(overloads),
        .i_power_good_flags(pgood), .o_port_pins_0_1_setup(p0), .o_port_pins_2_3_setup(p1),
        .o_port_pins_4_5_setup(p2), .o_port_pins_6_7_setup(p3), .o_port_pin_levels(levels),
        .o_duty_bank_zero(duty0), .o_duty_bank_one(duty1), .o_rail_switch_control(rail),
        .o_power_fail_keep_mask(keep), .o_operating_options(opts), .o_trim_rail_setpoint(trim),
        .o_step_up_current_setpoint(cur), .o_step_up_voltage_setpoint(volt),
        .o_fault_clear_cmd(clr), .o_fault_alert_out_b(alert_b));
    i2c_host_model host (.i_clk(clk), .i_sda_wire(sda_wire), .o_scl(scl), .o_sda_rel(sda_rel));
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    // reset stands for a core supply cycle; strap is sampled at the supply rise
    task automatic power(input logic s);
        rst_b  = 1'b0;
        supply = 1'b0;
        strap  = s;
        tick(5);
        rst_b = 1'b1;
        tick(2);
        supply = 1'b1;
        tick(10);
    endtask : power
    task automatic wr(input logic [7:0] o, input logic [7:0] v);
        logic a;
        host.start();
        host.send(dev, a);
        ack_ok = a;
        host.send(o, a);
        ack_ok = ack_ok & a;
        host.send(v, a);
        ack_ok = ack_ok & a;
        host.stop();
    endtask : wr
    task automatic rd(input logic [7:0] o, input int n);
        logic a;
        host.start();
        host.send(dev, a);
        host.send(o, a);
        host.start();
        host.send(dev | 8'h01, a);
        for (int i = 0; i < n; i++) host.recv(i < n - 1, rdq[i]);
        host.stop();
    endtask : rd
    task automatic hit(input logic [7:0] f);
        faults    = f;
        overloads = f;
        tick(2);
        faults    = 8'h00;
        overloads = 8'h00;
        tick(4);
    endtask : hit
    task automatic results;
        if (n_fail == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    // ************************************************************
    // stimulus
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // guards against a hung bus sequence
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        results();
    end
    initial begin
        {pins_in, faults, overloads} = 24'h00_0000;
        pgood = 8'hFD;
        dev   = pmic_regs_pkg::ADDR_WR_LOW;
        power(1'b0);
        `CHK("reset regs", 112'h0, all_regs)
        `CHK("reset alert", 1'b1, alert_b)
        foreach (rows[i]) begin
            wr(rows[i].ofs, rows[i].val);
            rd(rows[i].ofs, 1);
            `CHK("readback", rows[i].exp, rdq[0])
            `CHK("write ack", 1'b1, ack_ok)
        end
        `CHK("rail out", 8'hBF, rail)
        // pins 0, 1, 6, 7 are outputs after the rows above
        wr(pmic_regs_pkg::OFS_LEVELS, 8'hFF);
        `CHK("levels", 8'hC3, levels)
        pins_in = 8'h3C;
        rd(pmic_regs_pkg::OFS_LEVELS, 1);
        `CHK("levels read", 8'hFF, rdq[0])
        host.start();
        host.send(dev, k);
        host.send(8'h05, k);
        host.send(8'h11, k);
        host.send(8'h06, k);
        host.send(8'h22, k);
        host.stop();
        rd(8'h05, 3);
        `CHK("pair one", 8'h11, rdq[0])
        `CHK("pair two", 8'h22, rdq[1])
        `CHK("next reg", 8'hBF, rdq[2])
        host.start();
        host.send(8'h90, k);
        `CHK("foreign nack", 1'b0, k)
        host.send(8'h07, k);
        host.send(8'h00, k);
        host.stop();
        host.send(dev, k);
        `CHK("idle ignored", 1'b0, k)
        `CHK("rail kept", 8'hBF, rail)
        hit(8'h01);
        `CHK("alert set", 1'b0, alert_b)
        rd(pmic_regs_pkg::OFS_FAULT, 2);
        `CHK("fault flags", 8'h01, rdq[0])
        `CHK("overload", 8'h01, rdq[1])
        wr(pmic_regs_pkg::OFS_CLEAR, pmic_regs_pkg::CLEAR_CMD);
        tick(2);
        `CHK("alert clear", 1'b1, alert_b)
        `CHK("clear reg", 8'h01, clr)
        hit(8'h01);
        `CHK("held clear", 1'b1, alert_b)
        wr(pmic_regs_pkg::OFS_CLEAR, pmic_regs_pkg::REARM_CMD);
        hit(8'h01);
        `CHK("rearmed", 1'b0, alert_b)
        power(1'b1);
        `CHK("reset again", 112'h0, all_regs)
        host.start();
        host.send(pmic_regs_pkg::ADDR_WR_LOW, k);
        `CHK("low addr off", 1'b0, k)
        host.stop();
        dev = pmic_regs_pkg::ADDR_WR_HIGH;
        wr(8'h07, 8'h04);
        `CHK("high addr", 8'h04, rail)
        strap  = 1'b0;
        supply = 1'b0;
        tick(10);
        supply = 1'b1;
        tick(10);
        wr(8'h08, 8'h01);
        `CHK("addr held", 8'h01, keep)
        results();
    end
endmodule : pmic_i2c_slave_regs_test
`default_nettype wire

// ===== pmic_regs_pkg.sv
// constants, register map and link states of the two-wire register slave
// ****************************************************************************
// Operation
// - latch address select at supply rise
// - address held until core supply cycles
// - repeated start acts like start
// - ignore clock after stop or mismatch
// - bits msb first, stable while clock high
// - eight data bits plus acknowledge
// - acknowledge holds data low ninth clock
// - single write: pointer then data
// - repeated pointer/data pairs until stop
// - single read after pointer and restart
// - sequential read while master acknowledges
// - reset gives zeros, power good ones
// - setup registers: pwm, bank, pin config
// - port levels and two duty bytes
// - rail enable bit layout
// - shutdown keep mask, same layout; the code also drops bit 1 (BDh against BFh for rail)
// - mode register bit layout
// - set points: lockout plus six bits; the code keeps no lockout bit for the current set point (3Fh)
// - fault, overload, power good read only
// - identity: chip id and revision
// - clear command 01h clears, 00h rearms
// - slave only, up to 400 kHz
// - port write touches output pins only
// ****************************************************************************
`default_nettype none
package pmic_regs_pkg;
    localparam logic [7:0] ADDR_WR_LOW    = 8'h8E;
    localparam logic [7:0] ADDR_WR_HIGH   = 8'hCE;
    localparam logic [7:0] OFS_SETUP_LAST = 8'h03;
    localparam logic [7:0] OFS_LEVELS     = 8'h04;
    localparam logic [7:0] OFS_DUTY0      = 8'h05;
    localparam logic [7:0] OFS_DUTY1      = 8'h06;
    localparam logic [7:0] OFS_RAIL       = 8'h07;
    localparam logic [7:0] OFS_KEEP       = 8'h08;
    localparam logic [7:0] OFS_OPTS       = 8'h09;
    localparam logic [7:0] OFS_TRIM       = 8'h0A;
    localparam logic [7:0] OFS_CUR        = 8'h0B;
    localparam logic [7:0] OFS_VOLT       = 8'h0C;
    localparam logic [7:0] OFS_FAULT      = 8'h0D;
    localparam logic [7:0] OFS_OVER       = 8'h0E;
    localparam logic [7:0] OFS_PGOOD      = 8'h0F;
    localparam logic [7:0] OFS_IDENT      = 8'h10;
    localparam logic [7:0] OFS_CLEAR      = 8'h11;
    // used-bit masks; unused bits store and read as zero, except power good, which is FFh at reset and while cleared
    localparam logic [7:0] MASK_RAIL      = 8'hBF;
    localparam logic [7:0] MASK_KEEP      = 8'hBD;
    localparam logic [7:0] MASK_OPTS      = 8'hD9;
    localparam logic [7:0] MASK_SETPT     = 8'hBF;
    localparam logic [7:0] MASK_CUR       = 8'h3F;
    localparam logic [7:0] MASK_FAULT     = 8'hFB;
    localparam logic [7:0] MASK_RAILFLAG  = 8'hFD;
    localparam logic [7:0] RST_ZERO       = 8'h00;
    localparam logic [7:0] RST_PGOOD      = 8'hFF;
    localparam logic [7:0] CLEAR_CMD      = 8'h01;
    localparam logic [7:0] REARM_CMD      = 8'h00;
    // identity value is arbitrary
    localparam logic [7:0] IDENT_VALUE    = 8'h5A;
    localparam int         SCL_MAX_KHZ    = 400;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

    typedef enum logic [3:0] {
        LK_IDLE, LK_ADDR, LK_ADDR_ACK, LK_PTR, LK_PTR_ACK,
        LK_WDATA, LK_WDATA_ACK, LK_RDATA, LK_RACK, LK_RNEXT
    } link_state_t;
endpackage : pmic_regs_pkg
`default_nettype wire
